/* hw/perf_counter_error_status.sv */
`timescale 1ns/1ps
`include "perf_counter_error_status_consts.svh"
module perf_counter_error_status
(
    // clock and reset
    input  wire logic                                     sys_clk,
    input  wire logic                                     rst_n,
    // apb slave
    input  wire perf_counter_error_status_pkg::apb_req_t  apb_req,
    output      perf_counter_error_status_pkg::apb_rsp_t  apb_rsp,
    // event sources, one level per source id per cycle
    input  wire logic [29:0]                              event_in,
    // error strobes from pipeline units
    input  wire perf_counter_error_status_pkg::misc_err_t  misc_err_in,
    input  wire perf_counter_error_status_pkg::setup_err_t setup_err_in,
    // interrupt
    output      logic                                     irq
);
    perf_counter_error_status_pkg::state_t s_q;
    perf_counter_error_status_pkg::state_t s_d;

    // register index within a counter bank
    function automatic logic [3:0] reg_index(input logic [11:0] a);
        reg_index = a[`PCE_IDX_MSB:`PCE_IDX_LSB];
    endfunction

    function automatic logic in_value_bank(input logic [11:0] a);
        in_value_bank = ((a & `PCE_BANK_MASK) == `PCE_ADDR_VALUE_BASE);
    endfunction

    function automatic logic in_select_bank(input logic [11:0] a);
        in_select_bank = ((a & `PCE_BANK_MASK) == `PCE_ADDR_SELECT_BASE);
    endfunction

    // ids past the last source count nothing
    function automatic logic event_of(input logic [29:0] ev, input logic [4:0] sel);
        event_of = (sel < 5'(`PCE_NUM_SOURCES)) ? ev[sel] : 1'b0;
    endfunction

    // bus phases
    logic        setup_phase;
    logic        access_phase;
    logic        wr_en;
    logic        wr_commit;
    logic [11:0] addr;
    logic [31:0] wdata;

    // write strobes, high on the access edge only
    logic        wr_clear;
    logic        wr_enable;
    logic        wr_irq_status;
    logic        wr_irq_mask;
    logic        wr_value;
    logic        wr_select;
    logic [3:0]  wr_index;

    // read path
    logic [31:0] rdata;
    logic        hit;
    logic [15:0] misc_bits;
    logic [31:0] setup_word;

    // counter bank
    logic [15:0] clr;
    logic [15:0] value_wr;
    logic [15:0] select_wr;
    logic [15:0] counting;
    logic [15:0] wrapping;

    // interrupt sources
    logic [15:0] misc_new;
    logic [6:0]  setup_new;
    logic [2:0]  ev_set;
    logic [2:0]  irq_clear;

    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;
    assign wr_en        = access_phase && apb_req.pwrite;
    // a write lands only on the edge that also sees ready high
    assign wr_commit    = wr_en && s_q.rsp.pready;
    assign addr         = apb_req.paddr;
    assign wdata        = apb_req.pwdata;
    assign wr_index     = reg_index(addr);
    assign misc_bits    = s_q.misc;
    assign clr          = wr_clear ? wdata[`PCE_EN_MSB:0] : 16'h0; // R1

    // write decode; error registers are read-only and fall through
    always_comb
    begin
        wr_clear      = 1'b0;
        wr_enable     = 1'b0;
        wr_irq_status = 1'b0;
        wr_irq_mask   = 1'b0;
        wr_value      = 1'b0;
        wr_select     = 1'b0;
        if (wr_commit)
        begin
            if (addr == `PCE_ADDR_COUNTER_CLEAR)
            begin
                wr_clear = 1'b1; // R1
            end
            else if (addr == `PCE_ADDR_COUNTER_ENABLE)
            begin
                wr_enable = 1'b1; // R3
            end
            else if (addr == `PCE_ADDR_IRQ_STATUS)
            begin
                wr_irq_status = 1'b1;
            end
            else if (addr == `PCE_ADDR_IRQ_MASK)
            begin
                wr_irq_mask = 1'b1;
            end
            else if (in_value_bank(addr))
            begin
                wr_value = 1'b1; // R4
            end
            else if (in_select_bank(addr))
            begin
                wr_select = 1'b1; // R5
            end
        end
    end

    // setup error flags placed at their register bits
    always_comb
    begin
        setup_word = 32'h0;
        setup_word[`PCE_SETUP_FLT_MSB:`PCE_SETUP_FLT_LSB] =
            s_q.setup[`PCE_SETUP_HI_MSB:`PCE_SETUP_HI_LSB]; // R14
        setup_word[`PCE_SETUP_RD_MSB:`PCE_SETUP_RD_LSB] = s_q.setup[`PCE_SETUP_LO_MSB:0]; // R14
    end

    // read decode, reserved bits read zero
    always_comb
    begin
        rdata = 32'h0;
        hit   = 1'b1;
        if (addr == `PCE_ADDR_COUNTER_CLEAR)
        begin
            rdata = 32'h0; // R1
        end
        else if (addr == `PCE_ADDR_COUNTER_ENABLE)
        begin
            rdata = {16'h0, s_q.enable}; // R2
        end
        else if (addr == `PCE_ADDR_MISC_ERROR)
        begin
            rdata = {16'h0, misc_bits}; // R13
        end
        else if (addr == `PCE_ADDR_SETUP_ERROR)
        begin
            rdata = setup_word; // R14
        end
        else if (addr == `PCE_ADDR_IRQ_STATUS)
        begin
            rdata = {29'h0, s_q.irq_status};
        end
        else if (addr == `PCE_ADDR_IRQ_MASK)
        begin
            rdata = {29'h0, s_q.irq_mask};
        end
        else if (in_value_bank(addr))
        begin
            rdata = s_q.value[reg_index(addr)]; // R4
        end
        else if (in_select_bank(addr))
        begin
            rdata = {27'h0, s_q.select[reg_index(addr)]}; // R5
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // per counter: write targets, steps and wraps this cycle
    always_comb
    begin
        value_wr  = 16'h0;
        select_wr = 16'h0;
        counting  = 16'h0;
        wrapping  = 16'h0;
        for (int n = 0; n < `PCE_NUM_COUNTERS; n++)
        begin
            value_wr[n]  = wr_value && (wr_index == 4'(n));
            select_wr[n] = wr_select && (wr_index == 4'(n));
            counting[n]  = s_q.enable[n] && event_of(event_in, s_q.select[n]); // R3 R6 R7
            wrapping[n]  = counting[n] && (s_q.value[n] == `PCE_COUNT_MAX);
        end
    end

    // new errors only; the idle flag is status, not an event
    always_comb
    begin
        misc_new  = misc_err_in & ~s_q.misc & `PCE_MISC_EVENT_MASK;
        setup_new = setup_err_in & ~s_q.setup;
        ev_set    = 3'h0;
        ev_set[`PCE_IRQ_MISC_BIT]  = |misc_new;
        ev_set[`PCE_IRQ_SETUP_BIT] = |setup_new;
        // a step lost to a clear or a write is no wrap
        ev_set[`PCE_IRQ_WRAP_BIT]  = |(wrapping & ~clr & ~value_wr);
        irq_clear = wr_irq_status ? wdata[`PCE_IRQ_MSB:0] : 3'h0;
    end

    always_comb
    begin
        s_d = s_q;
        // no wait state: setup edge loads the answer, first access cycle shows it
        s_d.rsp.pready  = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        if (setup_phase && !apb_req.pwrite)
        begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = !hit;
            s_d.rsp.prdata  = rdata;
        end
        else if (setup_phase)
        begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = !hit;
            s_d.rsp.prdata  = 32'h0;
        end

        if (wr_enable)
        begin
            s_d.enable = wdata[`PCE_EN_MSB:0]; // R3
        end
        if (wr_irq_mask)
        begin
            s_d.irq_mask = wdata[`PCE_IRQ_MSB:0];
        end

        // clear beats a software write, which beats a step
        for (int n = 0; n < `PCE_NUM_COUNTERS; n++)
        begin
            if (clr[n])
            begin
                s_d.value[n] = 32'h0; // R1 R7
            end
            else if (value_wr[n])
            begin
                s_d.value[n] = wdata; // R4
            end
            else if (counting[n])
            begin
                s_d.value[n] = s_q.value[n] + 32'h1; // R7
            end
            if (select_wr[n])
            begin
                s_d.select[n] = wdata[`PCE_SEL_MSB:0]; // R5
            end
        end

        // sticky error capture, held until reset
        if (misc_err_in.cache_rx_overrun_err)
        begin
            s_d.misc.cache_rx_overrun_err = 1'b1; // R8 R15
        end
        if (misc_err_in.memctl_binner_err)
        begin
            s_d.misc.memctl_binner_err = 1'b1; // R8 R15
        end
        if (misc_err_in.memctl_renderer_err)
        begin
            s_d.misc.memctl_renderer_err = 1'b1; // R8 R15
        end
        // fetcher idle follows its source, it is not a fault
        s_d.misc.fetcher_idle = misc_err_in.fetcher_idle; // R9
        if (misc_err_in.fetcher_pointer_err)
        begin
            s_d.misc.fetcher_pointer_err = 1'b1; // R9 R15
        end
        if (misc_err_in.writer_overflow_err)
        begin
            s_d.misc.writer_overflow_err = 1'b1; // R10 R15
        end
        // vertex memory faults
        if (misc_err_in.vmem_size_err)
        begin
            s_d.misc.vmem_size_err = 1'b1; // R11 R15
        end
        if (misc_err_in.vmem_free_unalloc_err)
        begin
            s_d.misc.vmem_free_unalloc_err = 1'b1; // R11 R15
        end
        if (misc_err_in.vmem_write_unalloc_err)
        begin
            s_d.misc.vmem_write_unalloc_err = 1'b1; // R11 R15
        end
        if (misc_err_in.vmem_read_unalloc_err)
        begin
            s_d.misc.vmem_read_unalloc_err = 1'b1; // R11 R15
        end
        if (misc_err_in.vmem_read_range_err)
        begin
            s_d.misc.vmem_read_range_err = 1'b1; // R11 R15
        end
        if (misc_err_in.vmem_write_range_err)
        begin
            s_d.misc.vmem_write_range_err = 1'b1; // R11 R15
        end
        // allocator faults
        if (misc_err_in.alloc_render_limit_err)
        begin
            s_d.misc.alloc_render_limit_err = 1'b1; // R12 R15
        end
        if (misc_err_in.alloc_bin_limit_err)
        begin
            s_d.misc.alloc_bin_limit_err = 1'b1; // R12 R15
        end
        if (misc_err_in.alloc_too_big_err)
        begin
            s_d.misc.alloc_too_big_err = 1'b1; // R12 R15
        end
        if (misc_err_in.alloc_base_busy_err)
        begin
            s_d.misc.alloc_base_busy_err = 1'b1; // R12 R15
        end

        // primitive setup faults
        if (setup_err_in.setup_fpd_used_err)
        begin
            s_d.setup.setup_fpd_used_err = 1'b1; // R14 R15
        end
        if (setup_err_in.setup_valid_err)
        begin
            s_d.setup.setup_valid_err = 1'b1; // R14 R15
        end
        if (setup_err_in.setup_mult_err_2)
        begin
            s_d.setup.setup_mult_err_2 = 1'b1; // R14 R15
        end
        if (setup_err_in.setup_mult_err_1)
        begin
            s_d.setup.setup_mult_err_1 = 1'b1; // R14 R15
        end
        if (setup_err_in.setup_mult_err_0)
        begin
            s_d.setup.setup_mult_err_0 = 1'b1; // R14 R15
        end
        if (setup_err_in.vmem_read_err_b)
        begin
            s_d.setup.vmem_read_err_b = 1'b1; // R14 R15
        end
        if (setup_err_in.vmem_read_err_a)
        begin
            s_d.setup.vmem_read_err_a = 1'b1; // R14 R15
        end

        // set wins over a software clear in the same cycle
        for (int b = 0; b <= `PCE_IRQ_MSB; b++)
        begin
            if (ev_set[b])
            begin
                s_d.irq_status[b] = 1'b1;
            end
            else if (irq_clear[b])
            begin
                s_d.irq_status[b] = 1'b0;
            end
        end
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign apb_rsp = s_q.rsp;
    assign irq     = s_q.irq;
endmodule // perf_counter_error_status

/* shared/perf_counter_error_status_consts.svh */
// How it works
// R1 - clear register: write one to bit n zeroes counter n; zero leaves it.
// R2 - upper bits reserved; software writes zeros, reads may return anything.
// R3 - enable bits reset to zero; counter counts only while its bit is one.
// R4 - sixteen 32-bit count registers, read/write by software, reset to zero.
// R5 - each counter has a 5-bit read/write source select, reset zero.
// R6 - source select picks any of thirty event sources, ids 0 to 29.
// R7 - enabled counter adds one per selected event; clear beats increment.
// R8 - misc error bits 15..13: cache overrun, memctl binner, memctl renderer.
// R9 - misc error bit 12 fetcher idle, bit 11 fetcher pointer fault.
// R10 - misc error bit 10: vertex data writer address overflow.
// R11 - misc error bits 9..4: vertex memory faults.
// R12 - misc error bits 3..0: vertex memory allocator faults.
// R13 - misc error register read-only, resets zero, grouped by unit.
// R14 - setup error register: bits 20..16 setup faults, bits 2..1 read faults.
// R15 - error flags are sticky until device reset.
`ifndef PERF_COUNTER_ERROR_STATUS_CONSTS_SVH
`define PERF_COUNTER_ERROR_STATUS_CONSTS_SVH
`define PCE_NUM_COUNTERS     16
`define PCE_NUM_SOURCES      30
`define PCE_ADDR_COUNTER_CLEAR  12'h000
`define PCE_ADDR_COUNTER_ENABLE 12'h004
`define PCE_ADDR_MISC_ERROR     12'h008
`define PCE_ADDR_SETUP_ERROR    12'h00C
`define PCE_ADDR_IRQ_STATUS     12'h010
`define PCE_ADDR_IRQ_MASK       12'h014
`define PCE_ADDR_VALUE_BASE     12'h100
`define PCE_ADDR_SELECT_BASE    12'h180
`define PCE_BANK_MASK           12'hF80
`define PCE_IDX_LSB             2
`define PCE_IDX_MSB             5
`define PCE_SEL_MSB             4
`define PCE_MISC_MSB            15
`define PCE_SETUP_FLT_LSB       16
`define PCE_SETUP_FLT_MSB       20
`define PCE_SETUP_RD_LSB        1
`define PCE_SETUP_RD_MSB        2
`define PCE_FETCHER_IDLE_BIT    12
`define PCE_IRQ_MISC_BIT        0
`define PCE_IRQ_SETUP_BIT       1
`define PCE_IRQ_WRAP_BIT        2
`define PCE_IRQ_MSB             2
`define PCE_EN_MSB              15
`define PCE_SETUP_HI_LSB        2
`define PCE_SETUP_HI_MSB        6
`define PCE_SETUP_LO_MSB        1
`define PCE_MISC_EVENT_MASK     16'hEFFF
`define PCE_COUNT_MAX           32'hFFFF_FFFF
`endif

/* shared/perf_counter_error_status_pkg.sv */
package perf_counter_error_status_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    // one strobe per misc error source, bit position = register bit
    typedef struct packed {
        logic cache_rx_overrun_err;
        logic memctl_binner_err;
        logic memctl_renderer_err;
        logic fetcher_idle;
        logic fetcher_pointer_err;
        logic writer_overflow_err;
        logic vmem_size_err;
        logic vmem_free_unalloc_err;
        logic vmem_write_unalloc_err;
        logic vmem_read_unalloc_err;
        logic vmem_read_range_err;
        logic vmem_write_range_err;
        logic alloc_render_limit_err;
        logic alloc_bin_limit_err;
        logic alloc_too_big_err;
        logic alloc_base_busy_err;
    } misc_err_t;

    typedef struct packed {
        logic setup_fpd_used_err;
        logic setup_valid_err;
        logic setup_mult_err_2;
        logic setup_mult_err_1;
        logic setup_mult_err_0;
        logic vmem_read_err_b;
        logic vmem_read_err_a;
    } setup_err_t;

    typedef struct packed {
        logic [15:0]       enable;
        logic [15:0][31:0] value;
        logic [15:0][4:0]  select;
        misc_err_t         misc;
        setup_err_t        setup;
        logic [2:0]        irq_status;
        logic [2:0]        irq_mask;
        logic              irq;
        apb_rsp_t          rsp;
    } state_t;
endpackage

/* tb/pce_chk.sv */
`timescale 1ns/1ps
module pce_chk
(
    // clock and reset
    input wire logic                                      sys_clk,
    input wire logic                                      rst_n,
    // register bus
    input wire perf_counter_error_status_pkg::apb_req_t   apb_req,
    input wire perf_counter_error_status_pkg::apb_rsp_t   apb_rsp,
    // error strobes and interrupt
    input wire perf_counter_error_status_pkg::misc_err_t  misc_err_in,
    input wire perf_counter_error_status_pkg::setup_err_t setup_err_in,
    input wire logic                                      irq
);
    logic [15:0] ms_q;
    logic [6:0]  ss_q;
    // errors seen since reset, aligned with the register state
    always_ff @(posedge sys_clk) ms_q <= rst_n ? (ms_q | misc_err_in) : '0;
    always_ff @(posedge sys_clk) ss_q <= rst_n ? (ss_q | setup_err_in) : '0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence rd_s(a);
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == a;
    endsequence
    a_ready_access: assert property (setup_s |=> apb_rsp.pready)
        else $error("no ready in access phase");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_clear_reads_zero: assert property (rd_s(12'h000) |=> apb_rsp.prdata == 32'h0)
        else $error("clear register read not zero");
    a_misc_sticky_flags: assert property (rd_s(12'h008) |=>
        (apb_rsp.prdata[15:0] & 16'hEFFF) == ($past(ms_q) & 16'hEFFF))
        else $error("misc error flags wrong");
    a_setup_sticky_flags: assert property (rd_s(12'h00C) |=>
        {apb_rsp.prdata[20:16], apb_rsp.prdata[2:1]} == $past(ss_q))
        else $error("setup error flags wrong");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !apb_rsp.pready && !irq)
        else $error("outputs active in reset");
    a_unmapped_err: assert property (apb_req.psel && !apb_req.penable
        && apb_req.paddr inside {[12'h018:12'h0FC]} |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (apb_req.psel && !apb_req.penable
        && apb_req.paddr < 12'h018 |=> !apb_rsp.pslverr)
        else $error("mapped access refused");
endmodule // pce_chk

/* tb/pipe_model.sv */
`timescale 1ns/1ps
module pipe_model
(
    // clock
    input wire logic                                    sys_clk,
    // strobes toward the block
    output     logic [29:0]                             event_in,
    output     perf_counter_error_status_pkg::misc_err_t  misc_err_in,
    output     perf_counter_error_status_pkg::setup_err_t setup_err_in
);
    initial {event_in, misc_err_in, setup_err_in} = '0;
    // hold one pattern for n cycles, then go quiet
    task automatic pulse(input logic [29:0] ev, input logic [15:0] me,
                         input logic [6:0] se, input int n);
        repeat (n) @(posedge sys_clk) {event_in, misc_err_in, setup_err_in} <= {ev, me, se};
        @(posedge sys_clk) {event_in, misc_err_in, setup_err_in} <= '0;
    endtask
endmodule // pipe_model

/* tb/tb.sv */
`timescale 1ns/1ps
`include "perf_counter_error_status_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
    logic                                      sys_clk = 0;
    logic                                      rst_n = 0;
    perf_counter_error_status_pkg::apb_req_t   apb_req = '0;
    perf_counter_error_status_pkg::apb_rsp_t   apb_rsp;
    perf_counter_error_status_pkg::misc_err_t  misc_err_in;
    perf_counter_error_status_pkg::setup_err_t setup_err_in;
    logic [29:0]                               event_in, ev;
    logic [31:0]                               r, x, cnt [16];
    logic [15:0]                               en, me, ms = 0;
    logic [6:0]                                se, ss = 0;
    logic [4:0]                                sel [16];
    logic [2:0]                                sts = 0;
    logic                                      irq, e;
    int                                        failures = 0, total_checks = 0, cyc = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    perf_counter_error_status i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .event_in(event_in), .misc_err_in(misc_err_in),
        .setup_err_in(setup_err_in), .irq(irq));
    pipe_model i_pipe (.sys_clk(sys_clk), .event_in(event_in), .misc_err_in(misc_err_in),
        .setup_err_in(setup_err_in));
    task automatic final_report();
        $display("failures=%0d checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) if (++cyc == 8000)
    begin
        failures++;
        final_report();
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge sys_clk) apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk) apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1 && ++t < 50);
        if (t == 50) failures++;
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        `CHK(r, v)
    endtask
    function automatic logic [11:0] va(int n); return `PCE_ADDR_VALUE_BASE + 12'(4 * n); endfunction
    function automatic logic [11:0] sa(int n); return `PCE_ADDR_SELECT_BASE + 12'(4 * n); endfunction
    initial
    begin
        void'($urandom(38));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`PCE_ADDR_COUNTER_ENABLE, 32'h0);
        rd(`PCE_ADDR_COUNTER_CLEAR, 32'h0);
        rd(`PCE_ADDR_MISC_ERROR, 32'h0);
        rd(`PCE_ADDR_SETUP_ERROR, 32'h0);
        for (int n = 0; n < 16; n++)
        begin
            rd(va(n), 32'h0);
            rd(sa(n), 32'h0);
            cnt[n] = n ? $urandom : 32'hFFFF_FFFE;
            sel[n] = n ? 5'($urandom % 32) : 5'h00;
            apb(1'b1, va(n), cnt[n]);
            apb(1'b1, sa(n), {27'h0, sel[n]});
            rd(va(n), cnt[n]);
            rd(sa(n), {27'h0, sel[n]});
        end
        en = 16'($urandom) | 16'h0001;
        ev = 30'($urandom) | 30'h1;
        apb(1'b1, `PCE_ADDR_COUNTER_ENABLE, {16'h0, en});
        rd(`PCE_ADDR_COUNTER_ENABLE, {16'h0, en});
        i_pipe.pulse(ev, 16'h0, 7'h0, 5);
        repeat (2) @(posedge sys_clk);
        for (int n = 0; n < 16; n++)
        begin
            x = cnt[n] + 32'd5;
            if (en[n] && sel[n] < 30 && ev[sel[n]]) sts[2] = sts[2] | (x < cnt[n]);
            if (en[n] && sel[n] < 30 && ev[sel[n]]) cnt[n] = x;
            rd(va(n), cnt[n]);
        end
        me = 16'($urandom);
        apb(1'b1, `PCE_ADDR_COUNTER_CLEAR, {16'h0, me});
        for (int n = 0; n < 16; n++) cnt[n] = me[n] ? 32'h0 : cnt[n];
        for (int n = 0; n < 16; n++) rd(va(n), cnt[n]);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, `PCE_ADDR_IRQ_MASK, k ? 32'h0 : 32'h7);
            me = 16'($urandom) | 16'h1000;
            se = 7'($urandom) | 7'h01;
            i_pipe.pulse(30'h0, me, se, 1);
            repeat (2) @(posedge sys_clk);
            sts = sts | {1'b0, |(se & ~ss), |(me & 16'hEFFF & ~ms)};
            ms = ms | (me & 16'hEFFF);
            ss = ss | se;
            rd(`PCE_ADDR_MISC_ERROR, {16'h0, ms});
            rd(`PCE_ADDR_SETUP_ERROR, {11'h0, ss[6:2], 13'h0, ss[1:0], 1'b0});
            rd(`PCE_ADDR_IRQ_STATUS, {29'h0, sts});
            `CHK(irq, k ? 1'b0 : |sts)
            apb(1'b1, `PCE_ADDR_IRQ_STATUS, 32'h7);
            sts = 3'h0;
            rd(`PCE_ADDR_IRQ_STATUS, 32'h0);
        end
        apb(1'b1, `PCE_ADDR_MISC_ERROR, 32'hFFFF_FFFF);
        rd(`PCE_ADDR_MISC_ERROR, {16'h0, ms});
        apb(1'b0, 12'h020, 32'h0);
        `CHK({e, r}, 33'h1_0000_0000)
        final_report();
    end
endmodule // tb
bind perf_counter_error_status pce_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .misc_err_in(misc_err_in),
    .setup_err_in(setup_err_in), .irq(irq));
